// *** common/rrc_defs.svh ***
// Purpose: Offsets, field positions, reset values and counts for the rotate/round/carry unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef RRC_DEFS_SVH
`define RRC_DEFS_SVH

`define RRC_ACC_W        24
`define RRC_CNT_W        4
`define RRC_APB_AW       8

`define RRC_OFF_CTRL     8'h00
`define RRC_OFF_STEP     8'h04
`define RRC_OFF_ACC_X    8'h08
`define RRC_OFF_ACC_Y    8'h0c
`define RRC_OFF_ACC_Z    8'h10
`define RRC_OFF_ACC_R    8'h14
`define RRC_OFF_FLAGS    8'h18
`define RRC_OFF_STATUS   8'h1c

`define RRC_CTRL_OP_LO   0
`define RRC_CTRL_OP_HI   1
`define RRC_CTRL_SEL_LO  2
`define RRC_CTRL_SEL_HI  3
`define RRC_CTRL_HASCNT  4
`define RRC_CTRL_CNT_LO  8
`define RRC_CTRL_CNT_HI  11

`define RRC_FLAG_C       0
`define RRC_FLAG_O       1
`define RRC_FLAG_S       2
`define RRC_FLAG_Z       3

`define RRC_ACC_RST      24'h000000
`define RRC_FLAGS_RST    4'h0
`define RRC_DIV_STEPS    5'h18

`endif

// *** common/rrc_pkg.sv ***
// Purpose: Types for the rotate/round/carry unit
// Assumes: rrc_defs.svh supplies the numbers
// Notes:   State codes are one-hot
package rrc_pkg;

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_rot  = 4'b0010,
        st_div  = 4'b0100,
        st_fix  = 4'b1000
    } seq_state_t;

    typedef enum logic [1:0] {
        op_none                    = 2'h0,
        rotate_right_through_carry = 2'h1,
        op_round                   = 2'h2,
        force_carry_op             = 2'h3
    } op_code_t;

endpackage : rrc_pkg

// *** verilog/rotate_round_carry_ops.sv ***
// Purpose: Rotate-right through carry, rounding of x, and force-carry, with APB access
// Assumes: Synchronous active-low reset, inputs synchronous to clk
// Notes:   One wait state on every APB transfer
`timescale 1ns/1ps
`include "rrc_defs.svh"

module rotate_round_carry_ops
    import rrc_pkg::*;
#(
    parameter int ACC_W = `RRC_ACC_W,
    parameter int CNT_W = `RRC_CNT_W
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`RRC_APB_AW-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        busy
);

    // Register map packs a 24-bit word and a 4-bit count
    if (ACC_W != 24 || CNT_W != 4) begin : g_width_check
        $error("Unsupported width");
    end

    // Single rotate-through-carry step; returns {carry, value}
    function automatic logic [ACC_W:0] rot_step(input logic [ACC_W-1:0] v, input logic c);
        rot_step = {v[0], c, v[ACC_W-1:1]};
    endfunction : rot_step

    function automatic logic [3:0] rot_flags(input logic [ACC_W:0] r);
        rot_flags = {(r[ACC_W-1:0] == '0), r[ACC_W-1], 1'b0, r[ACC_W]};
    endfunction : rot_flags

    logic [ACC_W-1:0] acc [4];
    logic [ACC_W-1:0] next_acc [4];
    logic [3:0]       flags;
    logic [3:0]       next_flags;
    seq_state_t       state;
    seq_state_t       next_state;
    logic [1:0]       sel;
    logic [1:0]       next_sel;
    logic [CNT_W-1:0] left;
    logic [CNT_W-1:0] next_left;
    logic [ACC_W-1:0] step;
    logic [ACC_W-1:0] next_step;
    logic [ACC_W:0]   rem;
    logic [ACC_W:0]   next_rem;
    logic [ACC_W-1:0] quo;
    logic [ACC_W-1:0] next_quo;
    logic             neg;
    logic             next_neg;
    logic [4:0]       divn;
    logic [4:0]       next_divn;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    logic             next_busy;

    always_comb begin
        logic             acc_phase;
        logic             wr;
        logic [ACC_W:0]   r;
        logic [ACC_W:0]   sh;
        logic [ACC_W-1:0] mag;
        logic [ACC_W-1:0] res;
        acc_phase    = psel && penable && !pready;
        wr           = acc_phase && pwrite;
        r            = '0;
        sh           = '0;
        mag          = '0;
        res          = '0;
        next_acc     = acc;
        next_flags   = flags;
        next_state   = state;
        next_sel     = sel;
        next_left    = left;
        next_step    = step;
        next_rem     = rem;
        next_quo     = quo;
        next_neg     = neg;
        next_divn    = divn;
        next_prdata  = prdata;
        next_pready  = acc_phase;
        next_pslverr = 1'b0;

        case (state)
            st_idle: begin
            end
            st_rot: begin
                r = rot_step(acc[sel], flags[`RRC_FLAG_C]);
                next_acc[sel] = r[ACC_W-1:0];
                next_flags    = rot_flags(r);
                next_left     = left - CNT_W'(1);
                if (left == CNT_W'(1)) begin
                    next_state = st_idle;
                end
            end
            st_div: begin
                // Restoring division of |x| by the step, one quotient bit a cycle
                sh = {rem[ACC_W-1:0], quo[ACC_W-1]};
                next_quo = {quo[ACC_W-2:0], 1'b0};
                if (sh >= {1'b0, step}) begin
                    sh          = sh - {1'b0, step};
                    next_quo[0] = 1'b1;
                end
                next_rem  = sh;
                next_divn = divn - 5'h01;
                if (divn == 5'h01) begin
                    next_state = st_fix;
                end
            end
            st_fix: begin
                mag = quo * step;
                if ({rem[ACC_W-1:0], 1'b0} >= {1'b0, step}) begin
                    mag = mag + step;
                end
                res = neg ? (~mag + ACC_W'(1)) : mag;
                next_acc[0] = res;
                next_state  = st_idle;
            end
            default: begin
                next_state = st_idle;
            end
        endcase

        if (acc_phase) begin
            next_pslverr = 1'b1;
            case (paddr)
                `RRC_OFF_CTRL: next_pslverr = pwrite && (state != st_idle); // Refuse while a sequence runs
                `RRC_OFF_STEP: next_pslverr = 1'b0;
                `RRC_OFF_ACC_X, `RRC_OFF_ACC_Y, `RRC_OFF_ACC_Z, `RRC_OFF_ACC_R,
                `RRC_OFF_FLAGS: next_pslverr = pwrite && (state != st_idle);
                `RRC_OFF_STATUS: next_pslverr = pwrite;
                default: next_pslverr = 1'b1;
            endcase
            case (paddr)
                `RRC_OFF_CTRL:   next_prdata = 32'h0;
                `RRC_OFF_STEP:   next_prdata = {8'h0, step};
                `RRC_OFF_ACC_X:  next_prdata = {8'h0, acc[0]};
                `RRC_OFF_ACC_Y:  next_prdata = {8'h0, acc[1]};
                `RRC_OFF_ACC_Z:  next_prdata = {8'h0, acc[2]};
                `RRC_OFF_ACC_R:  next_prdata = {8'h0, acc[3]};
                `RRC_OFF_FLAGS:  next_prdata = {28'h0, flags};
                `RRC_OFF_STATUS: next_prdata = {31'h0, state != st_idle};
                default:         next_prdata = 32'h0;
            endcase
        end

        if (wr && state == st_idle) begin
            case (paddr)
                `RRC_OFF_CTRL: begin
                    next_sel = pwdata[`RRC_CTRL_SEL_HI:`RRC_CTRL_SEL_LO];
                    case (op_code_t'(pwdata[`RRC_CTRL_OP_HI:`RRC_CTRL_OP_LO]))
                        rotate_right_through_carry: begin
                            if (pwdata[`RRC_CTRL_HASCNT]) begin
                                // First cycle decodes, then one step per cycle
                                next_left  = pwdata[`RRC_CTRL_CNT_HI:`RRC_CTRL_CNT_LO];
                                next_state = (next_left == '0) ? st_idle : st_rot;
                            end else begin
                                r = rot_step(acc[next_sel], flags[`RRC_FLAG_C]);
                                next_acc[next_sel] = r[ACC_W-1:0];
                                next_flags         = rot_flags(r);
                            end
                        end
                        op_round: begin
                            // Step of zero cannot divide, so x is left as is
                            if (step != '0) begin
                                next_neg   = acc[0][ACC_W-1];
                                next_quo   = acc[0][ACC_W-1] ? (~acc[0] + ACC_W'(1)) : acc[0];
                                next_rem   = '0;
                                next_divn  = `RRC_DIV_STEPS;
                                next_state = st_div;
                            end
                        end
                        force_carry_op: begin
                            next_flags[`RRC_FLAG_C] = 1'b1;
                            next_flags[`RRC_FLAG_O] = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
                `RRC_OFF_STEP:  next_step = pwdata[ACC_W-1:0];
                `RRC_OFF_ACC_X: next_acc[0] = pwdata[ACC_W-1:0];
                `RRC_OFF_ACC_Y: next_acc[1] = pwdata[ACC_W-1:0];
                `RRC_OFF_ACC_Z: next_acc[2] = pwdata[ACC_W-1:0];
                `RRC_OFF_ACC_R: next_acc[3] = pwdata[ACC_W-1:0];
                `RRC_OFF_FLAGS: next_flags = pwdata[3:0];
                default: begin
                end
            endcase
        end else if (wr && paddr == `RRC_OFF_STEP) begin
            next_step = pwdata[ACC_W-1:0];
        end
        next_busy = (next_state != st_idle);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc     <= '{default: `RRC_ACC_RST};
            flags   <= `RRC_FLAGS_RST;
            state   <= st_idle;
            sel     <= 2'h0;
            left    <= '0;
            step    <= '0;
            rem     <= '0;
            quo     <= '0;
            neg     <= 1'b0;
            divn    <= 5'h0;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            busy    <= 1'b0;
        end else if (ce) begin
            acc     <= next_acc;
            flags   <= next_flags;
            state   <= next_state;
            sel     <= next_sel;
            left    <= next_left;
            step    <= next_step;
            rem     <= next_rem;
            quo     <= next_quo;
            neg     <= next_neg;
            divn    <= next_divn;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            busy    <= next_busy;
        end
    end

endmodule : rotate_round_carry_ops

// *** verif/rrc_properties.sv ***
// Purpose: Port assertions for the rotate/round/carry unit
// Assumes: ce may drop; frozen cycles are not counted
// Notes:   Bound to the top module
`timescale 1ns/1ps
module rrc_properties (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic       take;
    logic [5:0] run;
    assign take = psel && penable && !pready && ce;
    // Longest sequence is rounding, so the run never needs more
    always_ff @(posedge clk) run <= (!resetn || !busy) ? 6'h00 : (ce ? run + 6'h01 : run);
    answer_wait_a: assert property (take |=> pready) else $error("no answer after access");
    answer_pulse_a: assert property (pready && ce |=> !pready) else $error("answer held too long");
    rot_length_a: assert property (take && pwrite && paddr == 8'h00 && !busy && pwdata[1:0] == 2'h1 && pwdata[4]
        && pwdata[11:8] == 4'h3 |=> busy [*3] ##[1:2] !busy) else $error("count rotate length");
    no_count_a: assert property (take && pwrite && paddr == 8'h00 && !busy && pwdata[1:0] != 2'h2 && !pwdata[4]
        |=> !busy ##1 !busy) else $error("single op went busy");
    busy_bound_a: assert property (run <= 6'h1a) else $error("sequence too long");
    busy_cause_a: assert property ($rose(busy) |-> $past(take && pwrite && paddr == 8'h00))
        else $error("busy without an op");
    busy_refuse_a: assert property (take && pwrite && busy && paddr != 8'h04 && paddr <= 8'h18
        |=> pslverr) else $error("write accepted while busy");
    status_ro_a: assert property (take && pwrite && paddr == 8'h1c |=> pslverr) else $error("status written");
    unmapped_a: assert property (take && (paddr > 8'h1c || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped accepted");
    status_bits_a: assert property (take && !pwrite && paddr == 8'h1c |=> prdata[31:1] == 31'h0 && !pslverr)
        else $error("status upper bits");
endmodule : rrc_properties
bind rotate_round_carry_ops rrc_properties u_props (.clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .busy);

// *** verif/rrc_seq_model.sv ***
// Purpose: Decoder/sequencer model issuing APB transfers
// Assumes: Slave answers with pready
// Notes:   Request held until pready seen
`timescale 1ns/1ps
module rrc_seq_model (
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : rrc_seq_model

// *** verif/tb_rotate_round_carry_ops.sv ***
// Purpose: Self-checking bench for the rotate/round/carry unit
// Assumes: ce low only inside the freeze check
// Notes:   Hang cut by cycle ceiling
`timescale 1ns/1ps
module tb_rotate_round_carry_ops;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, busy, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] rin [4] = '{24'h000018, 24'h000019, 24'hffffe7, 24'hffffff};
    logic [23:0] rex [4] = '{24'h000014, 24'h00001e, 24'hffffe2, 24'h000000};
    int          mismatches = 0;
    int          checks_done = 0;
    int          cyc = 0;
    always #25 clk = ~clk;
    rotate_round_carry_ops DUT (.clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .busy);
    rrc_seq_model u_seq (.clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_seq.xfer(1'b1, a, d, q, e);
    endtask : wr
    task rd(input logic [7:0] a);
        u_seq.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
    task run_op(input logic [31:0] c);
        wr(8'h00, c);
        do rd(8'h1c); while (q[0] !== 1'b0);
    endtask : run_op
    task t_regs;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4));
            chk("reset value", q, 32'h0);
        end
        rd(8'h20);
        chk("unmapped error", {31'h0, e}, 32'h1);
        wr(8'h1c, 32'h1);
        chk("status write error", {31'h0, e}, 32'h1);
        wr(8'h08, 32'hffffffff);
        rd(8'h08);
        chk("acc width", q, 32'h00ffffff);
        $display("done regs");
    endtask : t_regs
    task t_rot;
        logic [23:0] v;
        logic        c;
        logic [3:0]  n;
        logic [1:0]  a;
        for (int s = 0; s < 5; s++) begin
            a = 2'(s);
            n = (s == 4) ? 4'h0 : (s == 1) ? 4'h3 : 4'(s * 5);
            wr(8'h08 + {4'h0, a, 2'h0}, 32'h3);
            wr(8'h18, 32'h9);
            v = 24'h000003;
            c = 1'b1;
            for (int k = 0; k < ((s == 4) ? 1 : int'(n)); k++) {v, c} = {c, v};
            run_op({20'h0, n, 3'h0, s != 4, a, 2'h1});
            rd(8'h08 + {4'h0, a, 2'h0});
            chk("rotated acc", q, {8'h0, v});
            rd(8'h18);
            chk("rotate flags", q, (s == 0) ? 32'h9 : {28'h0, v == 24'h0, v[23], 1'b0, c});
        end
        $display("done rotate");
    endtask : t_rot
    task t_busy;
        wr(8'h00, 32'h00000f11);
        // Without the freeze the 15 steps would be over long before this check
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        chk("frozen busy", {31'h0, busy}, 32'h1);
        ce <= 1'b1;
        wr(8'h08, 32'h0);
        chk("busy acc write error", {31'h0, e}, 32'h1);
        wr(8'h00, 32'h3);
        chk("busy op error", {31'h0, e}, 32'h1);
        run_op(32'h0);
        wr(8'h18, 32'ha);
        run_op(32'h3);
        rd(8'h18);
        chk("force carry flags", q, 32'h9);
        $display("done busy");
    endtask : t_busy
    task t_round;
        wr(8'h08, 32'h19);
        run_op(32'h2);
        rd(8'h08);
        chk("zero step keeps x", q, 32'h19);
        wr(8'h04, 32'ha);
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, {8'h0, rin[i]});
            run_op(32'h2);
            rd(8'h08);
            chk("rounded x", q, {8'h0, rex[i]});
        end
        $display("done round");
    endtask : t_round
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_rot;
        t_busy;
        t_round;
        test_done;
    end
endmodule : tb_rotate_round_carry_ops
